// ---- pkg/sadm_pkg.sv ----
// Purpose: Shared constants, types and helpers for the system address map router.
// Assumes: 32-bit byte addresses and a 32-bit data path on the core side.
// Notes:   Window bounds are inclusive.

package sadm_pkg;

   // ****************************************
   // Address map
   // ****************************************
   localparam logic [31:0] CODE_LAST     = 32'h1FFFFFFF;
   localparam logic [31:0] FLASH_LAST    = 32'h0003FFFF;
   localparam logic [31:0] SRAMC_BASE    = 32'h1FFF8000;
   localparam logic [31:0] SRAM_BASE     = 32'h20000000;
   localparam logic [31:0] SRAM_LAST     = 32'h20007FFF;
   localparam logic [31:0] SRAM_RGN_LAST = 32'h3FFFFFFF;
   localparam logic [31:0] BB_AREA_LAST  = 32'h200FFFFF;
   localparam logic [31:0] BB_ALIAS_BASE = 32'h22000000;
   localparam logic [31:0] BB_ALIAS_LAST = 32'h23FFFFFF;
   localparam logic [31:0] XM_BASE       = 32'h60000000;
   localparam logic [31:0] XM_LAST       = 32'h60FFFFFF;
   localparam logic [31:0] SYS_LO_LAST   = 32'hDFFFFFFF;
   localparam logic [31:0] PPB_BASE      = 32'hE0000000;
   localparam logic [31:0] PPB_LAST      = 32'hE00FFFFF;
   localparam int          BB_SHIFT      = 5;
   localparam int          XM_ADDR_W     = 24;
   localparam int          XM_BUS_CYCLES = 4;
   localparam logic [31:0] WORD_STEP     = 32'h00000004;

   // ****************************************
   // Peripheral windows
   // ****************************************
   localparam int          N_WIN   = 19;
   localparam logic [4:0]  WIN_CLK = 5'h00;
   localparam logic [4:0]  WIN_XMC = 5'h09;
   localparam logic [31:0] WIN_BASE [N_WIN] = '{
      32'h40004000, 32'h40004300, 32'h40004500, 32'h40004700, 32'h40004800,
      32'h40004900, 32'h40004E00, 32'h40004F00, 32'h40005000, 32'h40005400,
      32'h40005800, 32'h40006000, 32'h40006400, 32'h40007000, 32'h40008000,
      32'h4000A000, 32'h4000C000, 32'h40010000, 32'h48000000};
   localparam logic [31:0] WIN_LAST [N_WIN] = '{
      32'h400042FF, 32'h400043FF, 32'h400045FF, 32'h400047FF, 32'h400048FF,
      32'h400049FF, 32'h40004EFF, 32'h40004FFF, 32'h400051FF, 32'h400054FF,
      32'h40005FFF, 32'h400060FF, 32'h40006FFF, 32'h40007FFF, 32'h400087FF,
      32'h4000A400, 32'h4000C800, 32'h4001FFFF, 32'h48007FFF};

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [3:0] {
      T_NONE, T_FLASH, T_SRAM_CODE, T_SRAM, T_CLKCTL, T_PERIPH, T_XM_CTRL, T_XM_DATA, T_PPB
   } sadm_tgt_e;
   typedef enum logic [1:0] {BUS_INSTRUCTION_CODE_BUS, BUS_DATA_CODE_BUS, BUS_SYS, BUS_PPB} sadm_bus_e;
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_HALF = 2'h1;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic in_rng(input logic [31:0] a, lo, hi);
      return (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [31:0] bb_word(input logic [31:0] a);
      logic [31:0] o;
      o = (a - BB_ALIAS_BASE) >> BB_SHIFT;
      return SRAM_BASE + {o[31:2], 2'h0};
   endfunction

   function automatic logic [3:0] sz_mask(input logic [1:0] sz);
      return (sz == SZ_BYTE) ? 4'h1 : (sz == SZ_HALF) ? 4'h3 : 4'hF;
   endfunction

endpackage

// ---- pkg/sadm_dec_if.sv ----
// Purpose: Carries an address to the decoder and its verdict back.
// Assumes: Purely combinational use within one clock.
// Notes:   None.
`timescale 1ns/100ps

interface sadm_dec_if;
   import sadm_pkg::*;
   logic [31:0] addr;
   logic        fetch;
   sadm_tgt_e   tgt;
   sadm_bus_e   bus;
   logic [4:0]  win;
   logic        claim;
   logic        bb;
   modport dec  (input addr, fetch, output tgt, bus, win, claim, bb);
   modport core (output addr, fetch, input tgt, bus, win, claim, bb);
endinterface

// ---- core/sadm_addr_decode.sv ----
// Purpose: Combinational address decode into target, bus and window.
// Assumes: Address is stable for the cycle in which it is sampled.
// Notes:   Fetch legality for external memory is finished by the router.
`timescale 1ns/100ps

module sadm_addr_decode (
   sadm_dec_if.dec d
);
   import sadm_pkg::*;

   logic [N_WIN-1:0] win_hit;
   logic [4:0]       win_idx;

   wire in_code   = d.addr <= CODE_LAST;
   wire flash_hit = d.addr <= FLASH_LAST;
   wire sramc_hit = in_code && (d.addr >= SRAMC_BASE);
   wire sram_hit  = in_rng(d.addr, SRAM_BASE, SRAM_LAST);
   wire bb_hit    = in_rng(d.addr, BB_ALIAS_BASE, BB_ALIAS_LAST) && (bb_word(d.addr) <= SRAM_LAST);
   wire xm_hit    = in_rng(d.addr, XM_BASE, XM_LAST);
   wire ppb_hit   = in_rng(d.addr, PPB_BASE, PPB_LAST);
   wire win_any   = |win_hit;
   wire fetch_rng = in_code || in_rng(d.addr, SRAM_BASE, SRAM_RGN_LAST) || xm_hit;

   for (genvar i = 0; i < N_WIN; i++) begin : g_win
      assign win_hit[i] = in_rng(d.addr, WIN_BASE[i], WIN_LAST[i]);
   end

   always_comb begin
      win_idx = 5'h00;
      for (int i = N_WIN - 1; i >= 0; i--) begin
         if (win_hit[i]) begin
            win_idx = 5'(i);
         end
      end
   end

   assign d.win = win_idx;
   assign d.bb  = bb_hit;
   assign d.tgt = flash_hit ? T_FLASH :
                  sramc_hit ? T_SRAM_CODE :
                  (sram_hit || bb_hit) ? T_SRAM :
                  xm_hit ? T_XM_DATA :
                  ppb_hit ? T_PPB :
                  !win_any ? T_NONE :
                  (win_idx == WIN_CLK) ? T_CLKCTL :
                  (win_idx == WIN_XMC) ? T_XM_CTRL : T_PERIPH;
   assign d.bus = in_code ? (d.fetch ? BUS_INSTRUCTION_CODE_BUS : BUS_DATA_CODE_BUS) : ppb_hit ? BUS_PPB : BUS_SYS;
   assign d.claim = (d.tgt != T_NONE) && (!d.fetch || fetch_rng);
endmodule

// ---- core/sadm_router.sv ----
// Purpose: Routes core accesses by address to the memory and peripheral targets.
// Assumes: Requester holds its request until taken; targets answer with a done pulse.
// Notes:   One access is in flight at a time; bit-band writes hold the lock throughout.
`timescale 1ns/100ps

module sadm_router #(
   parameter int XM_CYCLES = sadm_pkg::XM_BUS_CYCLES
) (
   input  logic                core_clk,
   input  logic                clk_en,
   input  logic                rst,
   input  logic                req_valid,
   input  logic [31:0]         req_addr,
   input  logic                req_write,
   input  logic                req_fetch,
   input  logic [1:0]          req_size,
   input  logic [31:0]         req_wdata,
   input  logic                xm_width16,
   input  logic                xm_sync_en,
   input  logic                xm_async_en,
   input  logic                tgt_done,
   input  logic [31:0]         tgt_rdata,
   output logic                req_ready,
   output logic                rsp_valid,
   output logic                rsp_err,
   output logic [31:0]         rsp_rdata,
   output logic                tgt_valid,
   output sadm_pkg::sadm_bus_e tgt_bus,
   output sadm_pkg::sadm_tgt_e tgt_sel,
   output logic [4:0]          tgt_win,
   output logic [31:0]         tgt_addr,
   output logic                tgt_write,
   output logic                tgt_fetch,
   output logic [3:0]          tgt_be,
   output logic [31:0]         tgt_wdata,
   output logic                tgt_lock
);
   import sadm_pkg::*;

   localparam int CNT_W = $clog2(XM_CYCLES) + 1;

   typedef enum logic [1:0] {ST_IDLE, ST_BEAT, ST_BB_WR, ST_RESP} sadm_st_e;

   // ****************************************
   // Decode
   // ****************************************
   sadm_dec_if dec_if ();
   sadm_addr_decode u_dec (
      .d (dec_if)
   );
   assign dec_if.addr  = req_addr;
   assign dec_if.fetch = req_fetch;

   sadm_st_e    st_reg, st_next;
   logic        req_ready_reg, rsp_valid_reg, rsp_err_reg;
   logic [31:0] rsp_rdata_reg;
   logic        tgt_valid_reg, tgt_write_reg, tgt_fetch_reg, tgt_lock_reg;
   sadm_bus_e   tgt_bus_reg;
   sadm_tgt_e   tgt_sel_reg;
   logic [4:0]  tgt_win_reg;
   logic [31:0] tgt_addr_reg, tgt_wdata_reg, wd_hi_reg, rd_lo_reg;
   logic [3:0]  tgt_be_reg, be_hi_reg;
   logic        bb_reg, wr_reg, split_reg, beat_reg, bb_val_reg;
   logic [4:0]  bb_bit_reg;
   logic [1:0]  off_reg, sz_reg;
   logic [CNT_W-1:0] xm_cnt_reg;

   wire         xm_cfg_ok = xm_sync_en ^ xm_async_en;
   wire         is_xm     = dec_if.tgt == T_XM_DATA;
   wire         fetch_ok  = !req_fetch || !is_xm || xm_width16;
   wire         dec_err   = !dec_if.claim || (is_xm && (!xm_cfg_ok || !fetch_ok));
   wire         req_take  = clk_en && req_valid && req_ready_reg;
   wire         take_ok   = req_take && !dec_err;
   wire         take_err  = req_take && dec_err;
   wire         new_bb    = dec_if.bb;
   wire [7:0]   lanes     = 8'({4'h0, sz_mask(req_size)} << req_addr[1:0]);
   wire [63:0]  wshift    = 64'({32'h0, req_wdata} << {req_addr[1:0], 3'h0});
   wire [31:0]  first_adr = new_bb ? bb_word(req_addr) : {req_addr[31:2], 2'h0};
   wire         xm_last   = xm_cnt_reg == CNT_W'(XM_CYCLES - 1);
   wire         beat_done = tgt_done && (tgt_sel_reg != T_XM_DATA || xm_last);
   wire         fin       = (st_reg == ST_BEAT) && beat_done;
   wire         more      = fin && split_reg && !beat_reg;
   wire         bb_wr_go  = fin && bb_reg && wr_reg;
   wire         bb_wr_fin = (st_reg == ST_BB_WR) && tgt_done;
   wire         done_ok   = (fin && !more && !bb_wr_go) || bb_wr_fin;
   wire [63:0]  rd_pair   = beat_reg ? {tgt_rdata, rd_lo_reg} : {32'h0, tgt_rdata};
   wire [31:0]  rd_shift  = 32'(rd_pair >> {off_reg, 3'h0});
   wire [31:0]  rd_mask   = {{8{sz_reg[1]}}, {8{sz_reg[1]}}, {8{sz_reg != SZ_BYTE}}, 8'hFF};
   wire         bb_cur    = 1'(tgt_rdata >> bb_bit_reg);
   wire [31:0]  bb_new    = (tgt_rdata & ~(32'h1 << bb_bit_reg)) |
                            (32'(bb_val_reg) << bb_bit_reg);
   wire [31:0]  rd_result = bb_reg ? {31'h0, bb_cur} : (rd_shift & rd_mask);

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      unique case (st_reg)
         ST_IDLE:  st_next = take_err ? ST_RESP : (take_ok ? ST_BEAT : ST_IDLE);
         ST_BEAT:  st_next = more ? ST_BEAT : (bb_wr_go ? ST_BB_WR : (fin ? ST_RESP : ST_BEAT));
         ST_BB_WR: st_next = tgt_done ? ST_RESP : ST_BB_WR;
         ST_RESP:  st_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_reg        <= ST_IDLE;
         req_ready_reg <= 1'b0;
         rsp_valid_reg <= 1'b0;
         tgt_valid_reg <= 1'b0;
      end else if (clk_en) begin
         st_reg        <= st_next;
         req_ready_reg <= st_next == ST_IDLE;
         rsp_valid_reg <= st_next == ST_RESP;
         tgt_valid_reg <= (st_next == ST_BEAT) || (st_next == ST_BB_WR);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         xm_cnt_reg <= '0;
      end else if (clk_en) begin
         if (take_ok || more) begin
            xm_cnt_reg <= '0;
         end else if (st_reg == ST_BEAT && !xm_last) begin
            xm_cnt_reg <= xm_cnt_reg + CNT_W'(1);
         end
      end
   end

   // ****************************************
   // Request capture
   // ****************************************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tgt_bus_reg <= BUS_INSTRUCTION_CODE_BUS;
         tgt_sel_reg <= T_NONE;
         tgt_win_reg <= 5'h00;
         tgt_fetch_reg <= 1'b0;
         bb_reg <= 1'b0;
         wr_reg <= 1'b0;
         split_reg <= 1'b0;
         bb_val_reg <= 1'b0;
         bb_bit_reg <= 5'h00;
         off_reg <= 2'h0;
         sz_reg <= 2'h0;
         be_hi_reg <= 4'h0;
         wd_hi_reg <= 32'h0;
      end else if (clk_en && take_ok) begin
         tgt_bus_reg <= dec_if.bus;
         tgt_sel_reg <= dec_if.tgt;
         tgt_win_reg <= dec_if.win;
         tgt_fetch_reg <= req_fetch;
         bb_reg <= new_bb;
         wr_reg <= req_write;
         split_reg <= !new_bb && (lanes[7:4] != 4'h0);
         bb_val_reg <= req_wdata[0];
         bb_bit_reg <= req_addr[BB_SHIFT+1:2];
         off_reg <= new_bb ? 2'h0 : req_addr[1:0];
         sz_reg <= req_size;
         be_hi_reg <= lanes[7:4];
         wd_hi_reg <= wshift[63:32];
      end
   end

   // ****************************************
   // Target side beats
   // ****************************************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tgt_addr_reg <= 32'h0;
         tgt_be_reg <= 4'h0;
         tgt_wdata_reg <= 32'h0;
         tgt_write_reg <= 1'b0;
         tgt_lock_reg <= 1'b0;
         beat_reg <= 1'b0;
         rd_lo_reg <= 32'h0;
      end else if (clk_en) begin
         if (take_ok) begin
            tgt_addr_reg <= first_adr;
            tgt_be_reg <= new_bb ? 4'hF : lanes[3:0];
            tgt_wdata_reg <= wshift[31:0];
            tgt_write_reg <= req_write && !new_bb;
            tgt_lock_reg <= new_bb && req_write;
            beat_reg <= 1'b0;
         end else if (more) begin
            tgt_addr_reg <= tgt_addr_reg + WORD_STEP;
            tgt_be_reg <= be_hi_reg;
            tgt_wdata_reg <= wd_hi_reg;
            beat_reg <= 1'b1;
            rd_lo_reg <= tgt_rdata;
         end else if (bb_wr_go) begin
            tgt_write_reg <= 1'b1;
            tgt_wdata_reg <= bb_new;
            rd_lo_reg <= tgt_rdata;
         end else if (done_ok) begin
            tgt_lock_reg <= 1'b0;
            tgt_write_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rsp_err_reg <= 1'b0;
         rsp_rdata_reg <= 32'h0;
      end else if (clk_en && (take_err || done_ok)) begin
         rsp_err_reg <= take_err;
         rsp_rdata_reg <= (take_err || wr_reg) ? 32'h0 : rd_result;
      end
   end

   assign req_ready = req_ready_reg;
   assign rsp_valid = rsp_valid_reg;
   assign rsp_err   = rsp_err_reg;
   assign rsp_rdata = rsp_rdata_reg;
   assign tgt_valid = tgt_valid_reg;
   assign tgt_bus   = tgt_bus_reg;
   assign tgt_sel   = tgt_sel_reg;
   assign tgt_win   = tgt_win_reg;
   assign tgt_addr  = tgt_addr_reg;
   assign tgt_write = tgt_write_reg;
   assign tgt_fetch = tgt_fetch_reg;
   assign tgt_be    = tgt_be_reg;
   assign tgt_wdata = tgt_wdata_reg;
   assign tgt_lock  = tgt_lock_reg;

   // ****************************************
   // Checks
   // ****************************************
   // Sampling only enabled edges keeps cycle counts true across frozen stretches.
   default clocking cb_core @(posedge core_clk iff clk_en);
   endclocking
   default disable iff (rst);

   sequence s_bb_rd;
      tgt_valid_reg && tgt_lock_reg && !tgt_write_reg && tgt_done;
   endsequence
   sequence s_bb_wr;
      tgt_valid_reg && tgt_lock_reg && tgt_write_reg && (tgt_addr_reg == $past(tgt_addr_reg));
   endsequence

   property p_bb_rmw;
      s_bb_rd |=> s_bb_wr;
   endproperty
   a_bb_rmw : assert property (p_bb_rmw) else $error("Bit write did not follow read.");

   property p_bb_one;
      st_reg == ST_BB_WR |-> $onehot0(tgt_wdata_reg ^ rd_lo_reg);
   endproperty
   a_bb_one : assert property (p_bb_one) else $error("Bit write changed many bits.");

   property p_bb_rd;
      fin && bb_reg && !wr_reg |=>
         rsp_valid_reg && rsp_rdata_reg == {31'h0, 1'($past(tgt_rdata) >> bb_bit_reg)};
   endproperty
   a_bb_rd : assert property (p_bb_rd) else $error("Bit read value wrong.");

   property p_code_bus;
      tgt_valid_reg && tgt_bus_reg inside {BUS_INSTRUCTION_CODE_BUS, BUS_DATA_CODE_BUS} |-> tgt_addr_reg <= CODE_LAST;
   endproperty
   a_code_bus : assert property (p_code_bus) else $error("Code bus left code range.");

   property p_sys_bus;
      tgt_valid_reg && tgt_bus_reg == BUS_SYS |->
         in_rng(tgt_addr_reg, SRAM_BASE, SYS_LO_LAST) || tgt_addr_reg > PPB_LAST;
   endproperty
   a_sys_bus : assert property (p_sys_bus) else $error("System bus range wrong.");

   property p_sys_fetch;
      tgt_valid_reg && tgt_bus_reg == BUS_SYS && tgt_fetch_reg && tgt_sel_reg != T_XM_DATA
         |-> in_rng(tgt_addr_reg, SRAM_BASE, SRAM_RGN_LAST);
   endproperty
   a_sys_fetch : assert property (p_sys_fetch) else $error("Fetch outside range.");

   property p_xm_lim;
      tgt_valid_reg && tgt_sel_reg == T_XM_DATA |->
         (tgt_addr_reg >> XM_ADDR_W) == (XM_BASE >> XM_ADDR_W) && (!tgt_fetch_reg || xm_width16);
   endproperty
   a_xm_lim : assert property (p_xm_lim) else $error("External access out of limits.");

   property p_xm_hold;
      $rose(tgt_valid_reg) && tgt_sel_reg == T_XM_DATA |-> tgt_valid_reg [*4];
   endproperty
   a_xm_hold : assert property (p_xm_hold) else $error("External cycle too short.");

   property p_alias;
      take_ok && new_bb |=> tgt_addr_reg ==
         SRAM_BASE + ((($past(req_addr) - BB_ALIAS_BASE) >> BB_SHIFT) & ~32'h3);
   endproperty
   a_alias : assert property (p_alias) else $error("Alias word address wrong.");

   property p_err;
      take_err |=> rsp_valid_reg && rsp_err_reg && !tgt_valid_reg;
   endproperty
   a_err : assert property (p_err) else $error("Unclaimed access not refused.");

   property p_split;
      more |=> tgt_valid_reg && beat_reg && tgt_addr_reg == $past(tgt_addr_reg) + WORD_STEP;
   endproperty
   a_split : assert property (p_split) else $error("Second beat address wrong.");

   property p_bb_lock;
      bb_wr_fin |=> !tgt_lock_reg && rsp_valid_reg;
   endproperty
   a_bb_lock : assert property (p_bb_lock) else $error("Bit write lock held too long.");

endmodule

// ---- tb/sadm_tgt_model.sv ----
// Purpose: Behavioural memory standing behind the router's target port.
// Assumes: Address bits 9:2 select the word, which covers every scenario.
// Notes:   Slow mode holds back done for two cycles of each new request.
`timescale 1ns/100ps

module sadm_tgt_model (
   input  logic        core_clk,
   input  logic        rst,
   input  logic        slow,
   input  logic        tgt_valid,
   input  logic [31:0] tgt_addr,
   input  logic        tgt_write,
   input  logic [3:0]  tgt_be,
   input  logic [31:0] tgt_wdata,
   output logic        tgt_done,
   output logic [31:0] tgt_rdata
);
   logic [31:0] mem [256];
   logic [1:0]  cnt_reg;
   wire  [7:0]  idx = tgt_addr[9:2];

   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 32'h11223300 + i;
      end
   end

   assign tgt_done = tgt_valid & (~slow | cnt_reg[1]);
   // Released data lines show the inverse, so a stale word never passes.
   assign tgt_rdata = tgt_done ? mem[idx] : ~mem[idx];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst || !tgt_valid) begin
         cnt_reg <= 2'h0;
      end else if (!cnt_reg[1]) begin
         cnt_reg <= cnt_reg + 2'h1;
      end
   end

   always @(posedge core_clk) begin
      if (tgt_valid && tgt_done && tgt_write) begin
         for (int b = 0; b < 4; b++) begin
            if (tgt_be[b]) begin
               mem[idx][8*b +: 8] <= tgt_wdata[8*b +: 8];
            end
         end
      end
   end
endmodule

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the address map router.
// Assumes: Memory model answers every target beat.
// Notes:   Latency is counted in edges from the take edge to the answer.
`timescale 1ns/100ps

module tb_top;
   import sadm_pkg::*;
   // ****************************************
   // Signals
   // ****************************************
   logic        core_clk = 1'b0, rst = 1'b1, slow = 1'b0, clk_en = 1'b1;
   logic        req_valid = 1'b0, req_write = 1'b0, req_fetch = 1'b0;
   logic [31:0] req_addr = 32'h0, req_wdata = 32'h0;
   logic [1:0]  req_size = 2'h2;
   logic        xm_width16 = 1'b1, xm_sync_en = 1'b1, xm_async_en = 1'b0;
   logic        tgt_done, req_ready, rsp_valid, rsp_err, tgt_valid;
   logic        tgt_write, tgt_fetch, tgt_lock, lk;
   logic [31:0] tgt_rdata, rsp_rdata, tgt_addr, tgt_wdata, rd;
   logic [3:0]  tgt_be;
   logic [4:0]  tgt_win, b_win;
   sadm_bus_e   tgt_bus, b_bus;
   sadm_tgt_e   tgt_sel, b_sel;
   logic        er;
   int          failures = 0, num_checks = 0, beats = 0, lat;

   always #4 core_clk = ~core_clk;

   sadm_router sadm_router_inst (.core_clk(core_clk), .clk_en(clk_en), .rst(rst),
      .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write),
      .req_fetch(req_fetch), .req_size(req_size), .req_wdata(req_wdata),
      .xm_width16(xm_width16), .xm_sync_en(xm_sync_en), .xm_async_en(xm_async_en),
      .tgt_done(tgt_done), .tgt_rdata(tgt_rdata), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata),
      .tgt_valid(tgt_valid), .tgt_bus(tgt_bus), .tgt_sel(tgt_sel), .tgt_win(tgt_win),
      .tgt_addr(tgt_addr), .tgt_write(tgt_write), .tgt_fetch(tgt_fetch),
      .tgt_be(tgt_be), .tgt_wdata(tgt_wdata), .tgt_lock(tgt_lock));

   sadm_tgt_model sadm_tgt_model_inst (.core_clk(core_clk), .rst(rst), .slow(slow),
      .tgt_valid(tgt_valid), .tgt_addr(tgt_addr), .tgt_write(tgt_write),
      .tgt_be(tgt_be), .tgt_wdata(tgt_wdata), .tgt_done(tgt_done),
      .tgt_rdata(tgt_rdata));

   // Beat monitor keeps what the last accepted beat was routed to.
   always @(posedge core_clk) begin
      if (tgt_valid === 1'b1 && tgt_done === 1'b1) begin
         beats++;
         b_sel = tgt_sel;
         b_bus = tgt_bus;
         b_win = tgt_win;
      end
      if (tgt_lock === 1'b1) lk = 1'b1;
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input string name, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic acc(input logic [31:0] a, input logic w, f, input logic [1:0] sz,
                      input logic [31:0] wd);
      @(posedge core_clk);
      #1;
      req_valid = 1'b1; req_addr = a; req_write = w; req_fetch = f;
      req_size = sz; req_wdata = wd;
      for (int n = 0; n < 50 && req_ready !== 1'b1; n++) begin
         @(posedge core_clk);
         #1;
      end
      @(posedge core_clk);
      #1;
      req_valid = 1'b0;
      lat = 1;
      while (rsp_valid !== 1'b1 && lat < 60) begin
         @(posedge core_clk);
         #1;
         lat++;
      end
      if (rsp_valid !== 1'b1) failures++;
      rd = rsp_rdata;
      er = rsp_err;
   endtask

   task automatic t_map();
      logic [31:0] ad [10] = '{32'h00000000, 32'h1FFF8000, 32'h20000000, 32'h40004000,
         32'h40004300, 32'h40005400, 32'h60000000, 32'hE0000000, 32'h00000000,
         32'h20007FFC};
      logic [3:0] sl [10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h1, 4'h3};
      logic [1:0] bs [10] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h0, 2'h2};
      for (int i = 0; i < 10; i++) begin
         acc(ad[i], 1'b0, i >= 8, 2'h2, 32'h0);
         check("map error", er, 1'b0);
         check("map target", b_sel, sl[i]);
         check("map bus", b_bus, bs[i]);
         if (sl[i] == 4'h4 || sl[i] == 4'h6) check("window", b_win, sl[i] == 4'h6 ? 9 : 0);
      end
      check("sram read", rd, 32'h11223300 + 32'hFF);
   endtask

   task automatic t_err();
      logic [31:0] ad [5] = '{32'h40000000, 32'h40004400, 32'h22100000, 32'h61000000,
         32'h40004000};
      int b0;
      for (int i = 0; i < 5; i++) begin
         b0 = beats;
         acc(ad[i], 1'b0, i == 4, 2'h2, 32'h0);
         check("refusal", er, 1'b1);
         check("refusal latency", lat, 1);
         check("refused data", rd, 32'h0);
         check("refused beats", beats, b0);
      end
   endtask

   task automatic t_ext();
      slow = 1'b1;
      acc(32'h20000010, 1'b0, 1'b0, 2'h2, 32'h0);
      check("slow latency", lat, 4);
      slow = 1'b0;
      acc(32'h60000010, 1'b0, 1'b0, 2'h2, 32'h0);
      check("ext latency", lat, XM_BUS_CYCLES + 1);
      check("ext data", rd, 32'h11223304);
      xm_async_en = 1'b1;
      acc(32'h60000010, 1'b0, 1'b0, 2'h2, 32'h0);
      check("both types", er, 1'b1);
      xm_sync_en = 1'b0; xm_async_en = 1'b0;
      acc(32'h60000010, 1'b0, 1'b0, 2'h2, 32'h0);
      check("no type", er, 1'b1);
      xm_async_en = 1'b1; xm_width16 = 1'b0;
      acc(32'h60000010, 1'b0, 1'b1, 2'h1, 32'h0);
      check("narrow fetch", er, 1'b1);
      xm_width16 = 1'b1;
      acc(32'h60000010, 1'b0, 1'b1, 2'h1, 32'h0);
      check("wide fetch", er, 1'b0);
   endtask

   task automatic t_unal();
      int b0;
      b0 = beats;
      acc(32'h20000002, 1'b0, 1'b0, 2'h2, 32'h0);
      check("unaligned word", rd, 32'h33011122);
      check("unaligned beats", beats - b0, 2);
      b0 = beats;
      acc(32'h20000005, 1'b0, 1'b0, 2'h1, 32'h0);
      check("half at one", rd, 32'h00002233);
      check("half beats", beats - b0, 1);
   endtask

   task automatic t_bb();
      lk = 1'b0;
      acc(32'h2200000C, 1'b1, 1'b0, 2'h2, 32'h00000001);
      check("alias lock", lk, 1'b1);
      acc(32'h20000000, 1'b0, 1'b0, 2'h2, 32'h0);
      check("alias set", rd, 32'h11223308);
      acc(32'h2200000C, 1'b0, 1'b0, 2'h2, 32'h0);
      check("alias one", rd, 32'h1);
      acc(32'h22000000, 1'b0, 1'b0, 2'h2, 32'h0);
      check("alias zero", rd, 32'h0);
      acc(32'h220000A0, 1'b1, 1'b0, 2'h2, 32'hFFFFFFFE);
      acc(32'h20000004, 1'b0, 1'b0, 2'h2, 32'h0);
      check("alias clear", rd, 32'h11223201);
   endtask

   task automatic t_frz();
      fork
         acc(32'h20000010, 1'b0, 1'b0, 2'h2, 32'h0);
         begin
            repeat (2) @(posedge core_clk);
            #1;
            clk_en = 1'b0;
            repeat (3) @(posedge core_clk);
            #1;
            clk_en = 1'b1;
         end
      join
      check("frozen latency", lat, 5);
      check("frozen data", rd, 32'h11223304);
   endtask

   task automatic test_done();
      if (failures == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      repeat (5) @(posedge core_clk);
      #1;
      check("ready in reset", req_ready, 1'b0);
      check("answer in reset", rsp_valid, 1'b0);
      rst = 1'b0;
      t_map();
      t_err();
      t_unal();
      t_bb();
      t_ext();
      t_frz();
      test_done();
   end

   initial begin
      #60000;
      failures++;
      test_done();
   end
endmodule
